// ---- logic/spp_pkg.sv ----
// Operation
// - 8-bit address, 32-bit shared data bus
// - host drives select low to access
// - host drives read strobe low to read
// - host drives write strobe low to write
// - pick high loads host side, low protocol
// - host raises interrupt line toward chip
// - load enable high during firmware download
// - host drives load finished during download
// - host uses pio continue for pio handshake
// - no host interrupt while chip busy
// - host answers dma request with grant low
// - all signals are level sensitive
// - host loads both controllers after reset
// - registers are memory mapped to host
package spp_pkg;
  localparam int ADDR_W = 8;  // address bus width
  localparam int DATA_W = 32; // data bus width
  localparam logic [3:0] SETUP_CYC = 4'h1; // cycles address stands before strobe
  localparam logic [3:0] STROBE_CYC = 4'h2; // least strobe low time in cycles
  localparam logic [3:0] ZERO_CNT = 4'h0;   // counter reset value
  localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00; // idle address
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000; // idle data
  localparam logic [1:0] CMD_READ = 2'h1;   // command code: bus read
  localparam logic [1:0] CMD_WRITE = 2'h2;  // command code: bus write
  localparam logic [1:0] CMD_LOAD = 2'h3;   // command code: firmware word load
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_STROBE = 3'b010,
    ST_HOLD   = 3'b011,
    ST_DONE   = 3'b100
  } spp_state_t;
endpackage

// ---- logic/spp_sync_level.sv ----
`timescale 1ns/1ps
// registers a level input from the device side
module spp_sync_level import spp_pkg::*; #(
  parameter logic RST_VAL = 1'b0  // value held during reset
) (
  input  wire logic clk_sys_in,   // system clock
  input  wire logic resetn_in,    // synchronous reset, active low
  input  wire logic level_in,     // raw level from device
  output logic      level_out     // registered level
);
  logic next_level; // next registered value

  // take the level, or the idle value in reset
  always_comb begin
    next_level = resetn_in ? level_in : RST_VAL;
  end

  // register only
  always_ff @(posedge clk_sys_in) begin
    level_out <= next_level;
  end
endmodule

// ---- logic/spp_host_ctrl.sv ----
`timescale 1ns/1ps
// host side controller: runs device bus cycles, firmware load, irq and dma handshake
module spp_host_ctrl import spp_pkg::*; #(
  parameter int ADDR_WIDTH = ADDR_W,
  parameter int DATA_WIDTH = DATA_W
) (
  input  wire logic                  clk_sys_in,          // system clock
  input  wire logic                  resetn_in,           // synchronous reset, active low
  // user command port
  input  wire logic                  cmd_valid_in,        // command request level
  input  wire logic [1:0]            cmd_kind_in,         // read, write or load
  input  wire logic [ADDR_WIDTH-1:0] cmd_addr_in,         // register address
  input  wire logic [DATA_WIDTH-1:0] cmd_wdata_in,        // write data
  input  wire logic                  cmd_pick_in,         // load target: 1 host side ctrl
  output logic                       cmd_ready_out,       // idle, command may be taken
  output logic                       cmd_done_out,        // one-cycle completion pulse
  output logic [DATA_WIDTH-1:0]      cmd_rdata_out,       // read result
  input  wire logic                  load_mode_in,        // firmware download in progress
  input  wire logic                  load_finish_in,      // user says download finished
  input  wire logic                  irq_req_in,          // user wants to interrupt chip
  input  wire logic                  pio_in,              // user pio handshake level
  input  wire logic                  dma_accept_in,       // user accepts dma requests
  output logic                       dev_irq_out,         // registered chip interrupt
  output logic                       dev_ready_out,       // registered chip ready
  output logic                       dma_pending_out,     // chip requests dma
  // device pins
  output logic [ADDR_WIDTH-1:0]      addr_out,            // address bus
  output logic                       bus_select_low_out,  // chip select, active low
  output logic                       read_strobe_low_out, // read strobe, active low
  output logic                       write_strobe_low_out,// write strobe, active low
  output logic [DATA_WIDTH-1:0]      data_out,            // data bus drive value
  output logic                       data_oe_out,         // high while host drives data
  input  wire logic [DATA_WIDTH-1:0] data_in,             // data bus level
  output logic                       controller_pick_out, // download target
  output logic                       host_to_chip_irq_out,// interrupt to chip
  output logic                       firmware_load_enable_out, // download enable
  output logic                       load_finished_out,   // download finished
  output logic                       pio_continue_out,    // pio handshake
  output logic                       dma_grant_low_out,   // dma acknowledge, active low
  input  wire logic                  chip_to_host_irq_in, // interrupt from chip
  input  wire logic                  ready_in,            // chip ready
  input  wire logic                  busy_in,             // chip in service routine
  input  wire logic                  access_stall_low_in, // chip wait, active low
  input  wire logic                  dma_request_low_in   // chip dma request, active low
);
  spp_state_t                state, next_state;  // bus cycle sequencer
  logic [3:0]                cnt, next_cnt;      // phase counter
  logic [1:0]                kind, next_kind;    // latched command kind
  logic [ADDR_WIDTH-1:0]     next_addr;          // next address pins
  logic [DATA_WIDTH-1:0]     next_data;          // next data drive value
  logic [DATA_WIDTH-1:0]     next_rdata;         // next read result
  logic                      next_cs;            // next select, active low
  logic                      next_rd;            // next read strobe, active low
  logic                      next_wr;            // next write strobe, active low
  logic                      next_oe;            // next data drive enable
  logic                      next_done;          // next completion pulse
  logic                      next_rdy;           // next idle flag
  logic                      next_pick;          // next download target
  logic                      next_irq;           // next interrupt to chip
  logic                      next_load;          // next download enable
  logic                      next_fin;           // next download finished
  logic                      next_pio;           // next pio handshake
  logic                      next_dack;          // next dma grant, active low
  logic                      next_pend;          // next dma pending flag
  logic                      busy_q;             // registered busy level
  logic                      stall_q;            // registered wait level, active low
  logic                      dreq_q;             // registered dma request, active low

  // registered device levels, all level sensitive
  spp_sync_level #(.RST_VAL(1'b0)) u_irq (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .level_in   (chip_to_host_irq_in),
    .level_out  (dev_irq_out)
  );
  spp_sync_level #(.RST_VAL(1'b0)) u_rdy (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .level_in   (ready_in),
    .level_out  (dev_ready_out)
  );
  spp_sync_level #(.RST_VAL(1'b0)) u_busy (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .level_in   (busy_in),
    .level_out  (busy_q)
  );
  spp_sync_level #(.RST_VAL(1'b1)) u_stall (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .level_in   (access_stall_low_in),
    .level_out  (stall_q)
  );
  spp_sync_level #(.RST_VAL(1'b1)) u_dreq (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .level_in   (dma_request_low_in),
    .level_out  (dreq_q)
  );

  // bus cycle sequencer next state
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_kind  = kind;
    next_addr  = addr_out;
    next_data  = data_out;
    next_oe    = data_oe_out;
    next_cs    = bus_select_low_out;
    next_rd    = read_strobe_low_out;
    next_wr    = write_strobe_low_out;
    next_rdata = cmd_rdata_out;
    next_pick  = controller_pick_out;
    next_done  = 1'b0;
    next_rdy   = 1'b0;
    case (state)
      ST_IDLE: begin
        next_rdy = 1'b1;
        if (cmd_valid_in && cmd_ready_out) begin
          // address and select first, strobes later
          next_state = ST_SETUP;
          next_rdy   = 1'b0;
          next_cnt   = ZERO_CNT;
          next_kind  = cmd_kind_in;
          next_addr  = cmd_addr_in;
          next_cs    = 1'b0;
          if (cmd_kind_in != CMD_READ) begin
            next_data = cmd_wdata_in;
            next_oe   = 1'b1;
          end
          if (cmd_kind_in == CMD_LOAD) begin
            next_pick = cmd_pick_in;
          end
        end
      end
      ST_SETUP: begin
        next_cnt = cnt + 4'h1;
        if (cnt + 4'h1 >= SETUP_CYC) begin
          next_state = ST_STROBE;
          next_cnt   = ZERO_CNT;
          if (kind == CMD_READ) begin
            next_rd = 1'b0;
          end else begin
            next_wr = 1'b0;
          end
        end
      end
      ST_STROBE: begin
        if (cnt < STROBE_CYC) begin
          next_cnt = cnt + 4'h1;
        end
        // hold strobe while the chip asks to wait
        if (cnt + 4'h1 >= STROBE_CYC && stall_q) begin
          next_state = ST_HOLD;
          if (kind == CMD_READ) begin
            next_rdata = data_in;
          end
          next_rd = 1'b1;
          next_wr = 1'b1;
        end
      end
      ST_HOLD: begin
        // release select and data after strobes rise
        next_state = ST_DONE;
        next_cs    = 1'b1;
        next_oe    = 1'b0;
      end
      ST_DONE: begin
        next_state = ST_IDLE;
        next_done  = 1'b1;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (!resetn_in) begin
      // idle bus during reset
      next_state = ST_IDLE;
      next_cnt   = ZERO_CNT;
      next_kind  = CMD_READ;
      next_addr  = ADDR_RST;
      next_data  = DATA_RST;
      next_oe    = 1'b0;
      next_cs    = 1'b1;
      next_rd    = 1'b1;
      next_wr    = 1'b1;
      next_rdata = DATA_RST;
      next_pick  = 1'b0;
      next_done  = 1'b0;
      next_rdy   = 1'b0;
    end
  end

  // side band next values
  always_comb begin
    next_load = load_mode_in;
    next_fin  = load_mode_in & load_finish_in;
    next_irq  = irq_req_in & ~busy_q & ~busy_in;
    next_pio  = pio_in;
    next_dack = ~(dma_accept_in & ~dreq_q);
    next_pend = ~next_dack | ~dreq_q;                  // request seen or grant given
    if (!resetn_in) begin
      next_load = 1'b0;
      next_fin  = 1'b0;
      next_irq  = 1'b0;
      next_pio  = 1'b0;
      next_dack = 1'b1;
      next_pend = 1'b0;
    end
  end

  // register all state and pins
  always_ff @(posedge clk_sys_in) begin
    state                    <= next_state;
    cnt                      <= next_cnt;
    kind                     <= next_kind;
    addr_out                 <= next_addr;
    data_out                 <= next_data;
    data_oe_out              <= next_oe;
    bus_select_low_out       <= next_cs;
    read_strobe_low_out      <= next_rd;
    write_strobe_low_out     <= next_wr;
    cmd_rdata_out            <= next_rdata;
    controller_pick_out      <= next_pick;
    cmd_done_out             <= next_done;
    cmd_ready_out            <= next_rdy;
    firmware_load_enable_out <= next_load;
    load_finished_out        <= next_fin;
    host_to_chip_irq_out     <= next_irq;
    pio_continue_out         <= next_pio;
    dma_grant_low_out        <= next_dack;
    dma_pending_out          <= next_pend;
  end
endmodule

// ---- tb/spp_host_ctrl_monitor.sv ----
`timescale 1ns/1ps
// pin-level checks on the host controller
module spp_host_ctrl_monitor (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_ready_out,
  input wire logic cmd_done_out,
  input wire logic load_mode_in,
  input wire logic busy_in,
  input wire logic host_to_chip_irq_out,
  input wire logic firmware_load_enable_out,
  input wire logic bus_select_low_out,
  input wire logic read_strobe_low_out,
  input wire logic write_strobe_low_out,
  input wire logic data_oe_out,
  input wire logic dma_request_low_in,
  input wire logic dma_grant_low_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  AST_RST_IDLE: assert property (disable iff (1'b0) !resetn_in |=> bus_select_low_out
    && read_strobe_low_out && write_strobe_low_out && dma_grant_low_out && !data_oe_out)
    else $error("pins not idle after reset");
  AST_SEL_STROBE: assert property (!(read_strobe_low_out && write_strobe_low_out)
    |-> !bus_select_low_out) else $error("strobe without select");
  AST_ONE_STROBE: assert property (read_strobe_low_out || write_strobe_low_out)
    else $error("both strobes low");
  AST_WR_DRIVES: assert property (!write_strobe_low_out |-> data_oe_out)
    else $error("write strobe without data drive");
  AST_RD_FREE: assert property (!read_strobe_low_out |-> !data_oe_out)
    else $error("host drives data during read");
  AST_RD_LEN: assert property ($fell(read_strobe_low_out) |=> !read_strobe_low_out)
    else $error("read strobe too short");
  AST_IRQ_BUSY: assert property (busy_in [*3] |-> !host_to_chip_irq_out)
    else $error("interrupt raised while busy");
  AST_LOAD_EN: assert property (load_mode_in [*3] |-> firmware_load_enable_out)
    else $error("load enable not following mode");
  AST_DMA_GRANT: assert property (dma_request_low_in [*3] |-> dma_grant_low_out)
    else $error("grant held without request");
  AST_DONE_TIME: assert property (cmd_valid_in && cmd_ready_out |-> ##[6:60] cmd_done_out)
    else $error("command did not complete");
  // main scenarios reached
  COV_READ: cover property ($fell(read_strobe_low_out));
  COV_GRANT: cover property ($fell(dma_grant_low_out));
  COV_LOAD: cover property (firmware_load_enable_out && !write_strobe_low_out);
endmodule

bind spp_host_ctrl spp_host_ctrl_monitor i_mon (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
  .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .cmd_done_out(cmd_done_out),
  .load_mode_in(load_mode_in), .busy_in(busy_in), .host_to_chip_irq_out(host_to_chip_irq_out),
  .firmware_load_enable_out(firmware_load_enable_out), .bus_select_low_out(bus_select_low_out),
  .read_strobe_low_out(read_strobe_low_out), .write_strobe_low_out(write_strobe_low_out),
  .data_oe_out(data_oe_out), .dma_request_low_in(dma_request_low_in),
  .dma_grant_low_out(dma_grant_low_out));

// ---- tb/spp_dev_model.sv ----
`timescale 1ns/1ps
// device model: register file, firmware sink, side-band levels
module spp_dev_model (
  input  wire logic        clk_sys_in,
  input  wire logic        sel_low_in,
  input  wire logic        rd_low_in,
  input  wire logic        wr_low_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] bus_in,
  input  wire logic        fw_en_in,
  input  wire logic        pick_in,
  input  wire logic [2:0]  ctl_in,   // bench asks: dma, busy, irq
  input  wire logic [3:0]  stall_in, // wait cycles per access
  output logic [31:0]      data_out,
  output logic             irq_out,
  output logic             ready_out,
  output logic             busy_out,
  output logic             stall_low_out,
  output logic             dreq_low_out
);
  logic [31:0] regs [256];   // register file
  logic [31:0] last = '0;    // last value driven
  logic [3:0]  scnt = 4'h0;  // strobe cycles seen
  int          load_cnt [2]; // words loaded per controller
  logic        acc;          // selected access in progress
  assign acc = !sel_low_in && !(rd_low_in && wr_low_in);
  // released bus shows the inverse of the last value
  assign data_out = (acc && !rd_low_in) ? regs[addr_in] : ~last;
  assign stall_low_out = !(acc && scnt < stall_in);
  assign irq_out = ctl_in[0];
  assign busy_out = ctl_in[1];
  assign dreq_low_out = !ctl_in[2];
  assign ready_out = fw_en_in;
  // stores writes, counts firmware words once per strobe
  always @(posedge clk_sys_in) begin
    scnt <= acc ? scnt + 4'h1 : 4'h0;
    if (acc && !rd_low_in) last <= regs[addr_in];
    if (acc && !wr_low_in && scnt == 4'h0) begin
      if (fw_en_in) load_cnt[pick_in]++;
      else regs[addr_in] <= bus_in;
    end
  end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
// self-checking bench for the host controller
module testbench;
  import spp_pkg::*;
  logic        clk_sys_in, resetn_in, cmd_valid_in, cmd_pick_in, load_mode_in, load_finish_in;
  logic        irq_req_in, pio_in, dma_accept_in, cmd_ready_out, cmd_done_out, dev_irq_out;
  logic        dev_ready_out, dma_pending_out, bus_select_low_out, read_strobe_low_out;
  logic        write_strobe_low_out, data_oe_out, controller_pick_out, host_to_chip_irq_out;
  logic        firmware_load_enable_out, load_finished_out, pio_continue_out, dma_grant_low_out;
  logic        chip_to_host_irq_in, ready_in, busy_in, access_stall_low_in, dma_request_low_in;
  logic [1:0]  cmd_kind_in;
  logic [7:0]  cmd_addr_in, addr_out;
  logic [31:0] cmd_wdata_in, cmd_rdata_out, data_out, data_in, dev_data;
  logic [2:0]  ctl;
  logic [3:0]  stall_len;
  int          num_errors, tests_run, cyc, lat, base;
  assign data_in = data_oe_out ? data_out : dev_data; // resolved data bus
  spp_host_ctrl i_dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .cmd_valid_in(cmd_valid_in), .cmd_kind_in(cmd_kind_in), .cmd_addr_in(cmd_addr_in),
    .cmd_wdata_in(cmd_wdata_in), .cmd_pick_in(cmd_pick_in), .cmd_ready_out(cmd_ready_out),
    .cmd_done_out(cmd_done_out), .cmd_rdata_out(cmd_rdata_out), .load_mode_in(load_mode_in),
    .load_finish_in(load_finish_in), .irq_req_in(irq_req_in), .pio_in(pio_in),
    .dma_accept_in(dma_accept_in), .dev_irq_out(dev_irq_out), .dev_ready_out(dev_ready_out),
    .dma_pending_out(dma_pending_out), .addr_out(addr_out),
    .bus_select_low_out(bus_select_low_out), .read_strobe_low_out(read_strobe_low_out),
    .write_strobe_low_out(write_strobe_low_out), .data_out(data_out),
    .data_oe_out(data_oe_out), .data_in(data_in), .controller_pick_out(controller_pick_out),
    .host_to_chip_irq_out(host_to_chip_irq_out),
    .firmware_load_enable_out(firmware_load_enable_out),
    .load_finished_out(load_finished_out), .pio_continue_out(pio_continue_out),
    .dma_grant_low_out(dma_grant_low_out), .chip_to_host_irq_in(chip_to_host_irq_in),
    .ready_in(ready_in), .busy_in(busy_in), .access_stall_low_in(access_stall_low_in),
    .dma_request_low_in(dma_request_low_in));
  spp_dev_model i_dev (.clk_sys_in, .sel_low_in(bus_select_low_out),
    .rd_low_in(read_strobe_low_out), .wr_low_in(write_strobe_low_out), .addr_in(addr_out),
    .bus_in(data_in), .fw_en_in(firmware_load_enable_out), .pick_in(controller_pick_out),
    .ctl_in(ctl), .stall_in(stall_len), .data_out(dev_data), .irq_out(chip_to_host_irq_in),
    .ready_out(ready_in), .busy_out(busy_in), .stall_low_out(access_stall_low_in),
    .dreq_low_out(dma_request_low_in));
  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  // cycle ceiling cuts a hang short
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one command, waits for done and records latency
  task automatic run_cmd(input logic [1:0] k, input logic [7:0] a, input logic [31:0] d,
                         input logic p);
    for (int n = 0; n < 50 && cmd_ready_out !== 1'b1; n++) tick(1);
    cmd_kind_in = k;
    cmd_addr_in = a;
    cmd_wdata_in = d;
    cmd_pick_in = p;
    cmd_valid_in = 1'b1;
    tick(1);
    cmd_valid_in = 1'b0;
    for (lat = 1; lat < 60 && cmd_done_out !== 1'b1; lat++) tick(1);
    check({31'h0, cmd_done_out}, 32'h1);
  endtask
  task automatic rw_test();
    run_cmd(CMD_WRITE, 8'h00, 32'hA5A5_0001, 1'b0);
    run_cmd(CMD_WRITE, 8'hFF, 32'h5A5A_FFFE, 1'b0);
    run_cmd(CMD_READ, 8'h00, 32'h0000_0000, 1'b0);
    check(cmd_rdata_out, 32'hA5A5_0001);
    base = lat;
    check({31'h0, base == 6 || base == 7}, 32'h1);
    stall_len = 4'h3;
    run_cmd(CMD_READ, 8'hFF, 32'h0000_0000, 1'b0);
    check(cmd_rdata_out, 32'h5A5A_FFFE);
    check({31'h0, lat == base + 3}, 32'h1);
    stall_len = 4'h0;
  endtask
  task automatic load_test();
    load_mode_in = 1'b1;
    tick(3);
    check({31'h0, dev_ready_out}, 32'h1);
    run_cmd(CMD_LOAD, 8'h00, 32'h1111_0000, 1'b1);
    run_cmd(CMD_LOAD, 8'h04, 32'h2222_0000, 1'b0);
    check(i_dev.load_cnt[1] * 16 + i_dev.load_cnt[0], 32'h11);
    load_finish_in = 1'b1;
    tick(3);
    check({31'h0, load_finished_out}, 32'h1);
    load_mode_in = 1'b0;
    load_finish_in = 1'b0;
  endtask
  task automatic side_test();
    ctl = 3'h2;
    irq_req_in = 1'b1;
    tick(4);
    check({31'h0, host_to_chip_irq_out}, 32'h0);
    ctl = 3'h1;
    pio_in = 1'b1;
    tick(4);
    check({30'h0, host_to_chip_irq_out, dev_irq_out}, 32'h3);
    check({31'h0, pio_continue_out}, 32'h1);
    ctl = 3'h4;
    dma_accept_in = 1'b1;
    tick(4);
    check({30'h0, dma_grant_low_out, dma_pending_out}, 32'h1);
    ctl = 3'h0;
    tick(4);
    check({31'h0, dma_grant_low_out}, 32'h1);
  endtask
  // reset in the middle of a write leaves select, strobes, data drive and dma grant idle, then a read works again
  task automatic reset_test();
    cmd_kind_in = CMD_WRITE;
    cmd_addr_in = 8'h10;
    cmd_wdata_in = 32'hC3C3_0010;
    cmd_valid_in = 1'b1;
    tick(3);
    cmd_valid_in = 1'b0;
    resetn_in = 1'b0;
    tick(2);
    check({bus_select_low_out, read_strobe_low_out, write_strobe_low_out, data_oe_out}, 32'hE);
    check({30'h0, dma_grant_low_out, cmd_ready_out}, 32'h2);
    resetn_in = 1'b1;
    run_cmd(CMD_READ, 8'h00, 32'h0000_0000, 1'b0);
    check(cmd_rdata_out, 32'hA5A5_0001);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {resetn_in, cmd_valid_in, cmd_pick_in, load_mode_in, load_finish_in, irq_req_in} = '0;
    {pio_in, dma_accept_in, cmd_kind_in, cmd_addr_in, cmd_wdata_in} = '0;
    ctl = 3'h0;
    stall_len = 4'h0;
    tick(2);
    check({bus_select_low_out, read_strobe_low_out, write_strobe_low_out, data_oe_out}, 32'hE);
    tick(1);
    resetn_in = 1'b1;
    rw_test();
    load_test();
    side_test();
    reset_test();
    give_verdict();
  end
endmodule
